// ### core/flash_front_cfg.svh
`ifndef FLASH_FRONT_CFG_SVH
`define FLASH_FRONT_CFG_SVH

// ==========================================================
// Opcodes
`define OP_READ_SLOW 8'h03
`define OP_READ_FAST 8'h0B
`define OP_DUAL_OUTPUT_READ 8'h3B
`define OP_DUAL_ADDRESS_READ 8'hBB
`define OP_QUAD_OUTPUT_READ 8'h6B
`define OP_QUAD_ADDRESS_READ 8'hEB
`define OP_STATUS_READ 8'h05
`define OP_STATUS1_READ 8'h35
`define OP_ID_READ 8'h9F
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_VOLATILE_ENABLE 8'h50
`define OP_STATUS_WRITE 8'h01
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK32_ERASE 8'h52
`define OP_BLOCK64_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7
`define OP_SUSPEND_A 8'h75
`define OP_SUSPEND_B 8'hB0
`define OP_RESUME_A 8'h7A
`define OP_RESUME_B 8'h30
`define OP_POWER_DOWN 8'hB9
`define OP_RESET_ENABLE 8'h66
`define OP_RESET 8'h99

// ==========================================================
// Frame layout and address map
`define ADDR_BYTES 4'h3
`define MIN_BYTES_BARE 4'h1
`define MIN_BYTES_STATUS_WRITE 4'h2
`define MIN_BYTES_ERASE 4'h4
`define MIN_BYTES_PROGRAM 4'h5
`define SECTOR_MASK 24'h000FFF
`define BLOCK32_MASK 24'h007FFF
`define BLOCK64_MASK 24'h00FFFF
`define BYTE_BITS 4'h8

`endif

// ### core/flash_front_pkg.sv
`include "flash_front_cfg.svh"

package flash_front_pkg;

	// ==========================================================
	// Types
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_OPCODE = 7'h02,
		ST_ADDR = 7'h04,
		ST_DUMMY = 7'h08,
		ST_DATA_OUT = 7'h10,
		ST_DATA_IN = 7'h20,
		ST_STANDBY = 7'h40
	} state_t;

	typedef enum logic [1:0] {
		CLS_UNKNOWN = 2'h0,
		CLS_READ = 2'h1,
		CLS_WRITE = 2'h2
	} cmd_class_t;

	typedef enum logic [2:0] {
		ERASE_NONE = 3'h0,
		ERASE_SECTOR = 3'h1,
		ERASE_BLOCK32 = 3'h2,
		ERASE_BLOCK64 = 3'h3,
		ERASE_CHIP = 3'h4
	} erase_kind_t;

	typedef struct packed {
		cmd_class_t cls;
		logic [2:0] addr_w;
		logic [2:0] out_w;
		logic has_addr;
		logic dummy;
		logic quad;
		logic array;
		logic [3:0] min_bytes;
	} cmd_info_t;

	// ==========================================================
	// Opcode decode
	function automatic cmd_info_t decode(input logic [7:0] op);
		cmd_info_t i;
		i = '{CLS_UNKNOWN, 3'h1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, `MIN_BYTES_BARE};
		case (op)
			`OP_READ_SLOW: i = '{CLS_READ, 3'h1, 3'h1, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0};
			`OP_READ_FAST: i = '{CLS_READ, 3'h1, 3'h1, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0};
			`OP_DUAL_OUTPUT_READ: i = '{CLS_READ, 3'h1, 3'h2, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0};
			`OP_DUAL_ADDRESS_READ: i = '{CLS_READ, 3'h2, 3'h2, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0};
			`OP_QUAD_OUTPUT_READ: i = '{CLS_READ, 3'h1, 3'h4, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0};
			`OP_QUAD_ADDRESS_READ: i = '{CLS_READ, 3'h4, 3'h4, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0};
			`OP_STATUS_READ, `OP_STATUS1_READ, `OP_ID_READ:
				i = '{CLS_READ, 3'h1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0};
			`OP_WRITE_ENABLE, `OP_WRITE_DISABLE, `OP_VOLATILE_ENABLE, `OP_SUSPEND_A, `OP_SUSPEND_B,
			`OP_RESUME_A, `OP_RESUME_B, `OP_POWER_DOWN, `OP_RESET_ENABLE, `OP_RESET:
				i = '{CLS_WRITE, 3'h1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, `MIN_BYTES_BARE};
			`OP_STATUS_WRITE: i = '{CLS_WRITE, 3'h1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0, `MIN_BYTES_STATUS_WRITE};
			`OP_PAGE_PROGRAM: i = '{CLS_WRITE, 3'h1, 3'h1, 1'b1, 1'b0, 1'b0, 1'b1, `MIN_BYTES_PROGRAM};
			`OP_SECTOR_ERASE, `OP_BLOCK32_ERASE, `OP_BLOCK64_ERASE:
				i = '{CLS_WRITE, 3'h1, 3'h1, 1'b1, 1'b0, 1'b0, 1'b1, `MIN_BYTES_ERASE};
			`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
				i = '{CLS_WRITE, 3'h1, 3'h1, 1'b0, 1'b0, 1'b0, 1'b1, `MIN_BYTES_BARE};
			default: i.cls = CLS_UNKNOWN;
		endcase
		return i;
	endfunction : decode

endpackage : flash_front_pkg

// ### core/pin_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pin_if;
	logic sclk;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic [3:0] lanes;

	modport src (output sclk, sclk_rise, sclk_fall, cs_low, cs_fall, cs_rise, lanes);
	modport dst (input sclk, sclk_rise, sclk_fall, cs_low, cs_fall, cs_rise, lanes);
endinterface : pin_if

`default_nettype wire

// ### core/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Raw pins
	input wire logic sclk_pin,
	input wire logic cs_n_pin,
	input wire logic [3:0] lane_pin,
	// Synchronised view
	pin_if.src pins
);

	// ==========================================================
	// Two-flop synchronisers, plus one stage for edge detection
	logic [5:0] meta;
	logic [5:0] sync;
	logic [1:0] last;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			meta <= 6'h03;
			sync <= 6'h03;
			last <= 2'h3;
		end else begin
			meta <= {lane_pin, cs_n_pin, sclk_pin};
			sync <= meta;
			last <= sync[1:0];
		end
	end

	// Edges compare the second and third stages, never the first
	assign pins.sclk = sync[0];
	assign pins.sclk_rise = sync[0] && !last[0];
	assign pins.sclk_fall = !sync[0] && last[0];
	assign pins.cs_low = !sync[1];
	assign pins.cs_fall = !sync[1] && last[1];
	assign pins.cs_rise = sync[1] && !last[1];
	assign pins.lanes = sync[5:2];

endmodule : pin_sync

`default_nettype wire

// ### core/serial_flash_spi_front_end.sv
// Contract
// - Erase by sector, 32K/64K block, whole chip
// - Unknown opcode: standby until chip select rises
// - Standby keeps data output undriven
// - Valid command stays active until select rises
// - Sample on clock rise, drive on fall
// - Reads stream data; host may stop anytime
// - Write-type commands need byte-aligned select rise
// - Busy device ignores array access attempts
// - Standard mode: clock, select, in, out
// - Dual reads use two bidirectional lanes
// - Quad reads use four lanes incl. pause
// - Quad commands need quad enable bit
// - Pause stalls serial link, not internal work
// - Pause starts on pause low, clock low
// - Pause ends on pause high, clock low
// - Output undriven while pause pin low
// - Input ignored while paused
// - Select rise during pause resets interface
// - No pause during quad transfers
// - Dual output: even bits lane0, odd lane1
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_cfg.svh"

module serial_flash_spi_front_end #(
	parameter logic [23:0] ARRAY_LAST = 24'h03FFFF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Serial pins; lane3 doubles as pause
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] lane_in,
	output logic [3:0] lane_out,
	output logic [3:0] lane_oe,
	// Device core status
	input wire logic busy,
	input wire logic quad_enable_bit,
	// Read data path
	output logic rd_req,
	output logic [23:0] rd_addr,
	input wire logic [7:0] rd_data,
	// Write data and command commit
	output logic wr_byte_valid,
	output logic [7:0] wr_byte,
	output logic cmd_strobe,
	output logic [7:0] cmd_opcode,
	output logic [23:0] cmd_addr,
	output flash_front_pkg::erase_kind_t erase_kind,
	output logic [23:0] erase_first,
	output logic [23:0] erase_last,
	output logic in_standby
);
	import flash_front_pkg::*;

	pin_if pins();

	pin_sync u_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.sclk_pin(sclk),
		.cs_n_pin(cs_n),
		.lane_pin(lane_in),
		.pins(pins)
	);

	// ==========================================================
	// State
	state_t state;
	state_t next_state;
	cmd_info_t info;
	logic [3:0] bit_cnt;
	logic [3:0] byte_cnt;
	logic [7:0] in_sr;
	logic [23:0] addr;
	logic paused;
	logic [7:0] out_sr;
	logic [3:0] out_cnt;

	// ==========================================================
	// Input sampling
	wire addr_phase = (state == ST_ADDR) || (state == ST_DUMMY);
	wire [2:0] w_in = addr_phase ? info.addr_w : 3'h1;
	wire receiving = (state == ST_OPCODE) || addr_phase || (state == ST_DATA_IN);
	wire take_bit = pins.sclk_rise && pins.cs_low && !paused && receiving;
	wire [7:0] shifted = (w_in == 3'h4) ? {in_sr[3:0], pins.lanes} :
		(w_in == 3'h2) ? {in_sr[5:0], pins.lanes[1:0]} : {in_sr[6:0], pins.lanes[0]};
	wire [3:0] next_bit_cnt = bit_cnt + {1'b0, w_in};
	wire byte_done = take_bit && (next_bit_cnt == `BYTE_BITS);
	wire cmd_info_t dec = decode(shifted);

	// Rejections at opcode time
	wire quad_refused = dec.quad && !quad_enable_bit;
	wire busy_refused = dec.array && busy && (dec.cls == CLS_READ);
	wire opcode_bad = (dec.cls == CLS_UNKNOWN) || quad_refused || busy_refused;

	// ==========================================================
	// Pause handling
	// Lane3 is the pause pin unless a quad transfer owns it
	wire quad_xfer = info.quad && (addr_phase || (state == ST_DATA_OUT));
	wire pause_pin_low = !pins.lanes[3] && !quad_xfer;
	wire next_paused = pins.cs_low && !quad_xfer &&
		(paused ? !(pins.lanes[3] && !pins.sclk) : (!pins.lanes[3] && !pins.sclk));

	// ==========================================================
	// Next state
	always_comb begin
		next_state = state;
		if (pins.cs_rise) begin
			next_state = ST_IDLE;
		end else if (pins.cs_fall) begin
			next_state = ST_OPCODE;
		end else if (byte_done) begin
			unique case (state)
				ST_OPCODE: begin
					if (opcode_bad) begin
						next_state = ST_STANDBY;
					end else if (dec.cls == CLS_WRITE) begin
						next_state = ST_DATA_IN;
					end else if (dec.has_addr) begin
						next_state = ST_ADDR;
					end else begin
						next_state = ST_DATA_OUT;
					end
				end
				ST_ADDR: begin
					if (byte_cnt == `ADDR_BYTES) begin
						next_state = info.dummy ? ST_DUMMY : ST_DATA_OUT;
					end
				end
				ST_DUMMY: next_state = ST_DATA_OUT;
				ST_IDLE, ST_DATA_OUT, ST_DATA_IN, ST_STANDBY: next_state = state;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			paused <= 1'b0;
		end else begin
			state <= next_state;
			paused <= next_paused;
		end
	end

	// ==========================================================
	// Opcode, counters, address
	wire addr_byte = byte_done && (byte_cnt != 4'h0) && (byte_cnt <= `ADDR_BYTES) &&
		(state == ST_ADDR || (state == ST_DATA_IN && info.has_addr));

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= 4'h0;
			byte_cnt <= 4'h0;
			in_sr <= 8'h00;
			info <= '0;
			cmd_opcode <= 8'h00;
		end else if (pins.cs_fall) begin
			bit_cnt <= 4'h0;
			byte_cnt <= 4'h0;
		end else if (take_bit) begin
			in_sr <= shifted;
			bit_cnt <= byte_done ? 4'h0 : next_bit_cnt;
			if (byte_done && byte_cnt != 4'hF) begin
				byte_cnt <= byte_cnt + 4'h1;
			end
			if (byte_done && state == ST_OPCODE) begin
				info <= dec;
				cmd_opcode <= shifted;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			addr <= 24'h000000;
		end else if (pins.cs_fall) begin
			addr <= 24'h000000;
		end else if (addr_byte) begin
			addr <= {addr[15:0], shifted};
		end
	end

	// ==========================================================
	// Read data out
	wire enter_out = (next_state == ST_DATA_OUT) && (state != ST_DATA_OUT);
	wire out_fire = pins.sclk_fall && pins.cs_low && !paused && (state == ST_DATA_OUT);
	wire [7:0] word = (out_cnt == 4'h0) ? rd_data : out_sr;
	wire [3:0] out_base = (out_cnt == 4'h0) ? `BYTE_BITS : out_cnt;
	wire [3:0] next_out_cnt = out_base - {1'b0, info.out_w};
	wire [7:0] next_out_sr = (info.out_w == 3'h4) ? {word[3:0], 4'h0} :
		(info.out_w == 3'h2) ? {word[5:0], 2'h0} : {word[6:0], 1'b0};
	// Lane order: quad puts bit 7 on lane3; dual puts odd bits on lane1
	wire [3:0] next_lane_out = (info.out_w == 3'h4) ? word[7:4] :
		(info.out_w == 3'h2) ? {2'h0, word[7], word[6]} : {2'h0, word[7], 1'b0};
	wire [3:0] width_mask = (info.out_w == 3'h4) ? 4'hF : (info.out_w == 3'h2) ? 4'h3 : 4'h2;
	// Output is dropped as soon as the pause pin falls, before the pause itself begins
	wire drive = (state == ST_DATA_OUT) && pins.cs_low && !paused && !pause_pin_low;
	wire [3:0] next_lane_oe = drive ? width_mask : 4'h0;
	wire refill = out_fire && (next_out_cnt == 4'h0);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			out_sr <= 8'h00;
			out_cnt <= 4'h0;
			lane_out <= 4'h0;
		end else if (enter_out) begin
			out_cnt <= 4'h0;
		end else if (out_fire) begin
			out_sr <= next_out_sr;
			out_cnt <= next_out_cnt;
			lane_out <= next_lane_out;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lane_oe <= 4'h0;
			in_standby <= 1'b0;
		end else begin
			lane_oe <= next_lane_oe;
			in_standby <= (next_state == ST_STANDBY);
		end
	end

	// Next byte is requested as the last bits of the previous one shift out, so it has one serial clock period to arrive
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rd_req <= 1'b0;
			rd_addr <= 24'h000000;
		end else begin
			rd_req <= enter_out || refill;
			if (enter_out) begin
				rd_addr <= (state == ST_ADDR) ? {addr[15:0], shifted} : addr;
			end else if (refill) begin
				rd_addr <= rd_addr + 24'h000001;
			end
		end
	end

	// ==========================================================
	// Write-type commands and commit
	wire data_byte = byte_done && (state == ST_DATA_IN) &&
		(byte_cnt > (info.has_addr ? `ADDR_BYTES : 4'h0));
	wire aligned = (bit_cnt == 4'h0) && (byte_cnt >= info.min_bytes);
	wire commit = pins.cs_rise && (state == ST_DATA_IN) && aligned && !paused &&
		!(info.array && busy);

	erase_kind_t next_kind;
	logic [23:0] kind_mask;

	always_comb begin
		next_kind = ERASE_NONE;
		kind_mask = 24'h000000;
		unique case (cmd_opcode)
			`OP_SECTOR_ERASE: begin
				next_kind = ERASE_SECTOR;
				kind_mask = `SECTOR_MASK;
			end
			`OP_BLOCK32_ERASE: begin
				next_kind = ERASE_BLOCK32;
				kind_mask = `BLOCK32_MASK;
			end
			`OP_BLOCK64_ERASE: begin
				next_kind = ERASE_BLOCK64;
				kind_mask = `BLOCK64_MASK;
			end
			`OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
				next_kind = ERASE_CHIP;
				kind_mask = ARRAY_LAST;
			end
			default: next_kind = ERASE_NONE;
		endcase
	end

	wire [23:0] range_first = (next_kind == ERASE_CHIP) ? 24'h000000 : (addr & ~kind_mask);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_byte_valid <= 1'b0;
			wr_byte <= 8'h00;
		end else begin
			wr_byte_valid <= data_byte;
			if (data_byte) begin
				wr_byte <= shifted;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_strobe <= 1'b0;
			cmd_addr <= 24'h000000;
			erase_kind <= ERASE_NONE;
			erase_first <= 24'h000000;
			erase_last <= 24'h000000;
		end else begin
			cmd_strobe <= commit;
			if (commit) begin
				cmd_addr <= addr;
				erase_kind <= next_kind;
				erase_first <= range_first;
				erase_last <= range_first | kind_mask;
			end
		end
	end

endmodule : serial_flash_spi_front_end

`default_nettype wire

// ### testbench/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host side of the link, 400 ns serial clock
module spi_host_model (
	// Pins toward the device
	output logic sclk,
	output logic cs_n,
	output logic [3:0] lanes,
	// Resolved lane level
	input wire logic [3:0] wire_lv
);
	logic mode3;

	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		lanes = 4'hF;
		mode3 = 1'b1;
	end

	task automatic start(input logic m);
		mode3 = m;
		sclk = m;
		#400 cs_n = 1'b0;
		#200;
	endtask : start

	// Released lanes toggle so a stale level never looks valid
	task automatic xbyte(input logic [7:0] b, input int w, input int rw, output logic [7:0] r);
		logic [7:0] s;
		int k;
		s = b;
		r = 8'h00;
		for (k = 0; k < 8 / rw; k++) begin
			sclk = 1'b0;
			case (w)
				1: lanes[0] = s[7];
				2: lanes[1:0] = s[7:6];
				4: lanes = s[7:4];
				default: lanes = lanes ^ ((rw == 1) ? 4'h2 : 4'((1 << rw) - 1));
			endcase
			s = s << w;
			#200 sclk = 1'b1;
			// Single output comes back on lane1, wider reads on the low lanes
			#190 r = (rw == 1) ? {r[6:0], wire_lv[1]} : ((r << rw) | 8'(wire_lv & 4'((1 << rw) - 1)));
			#10;
		end
	endtask : xbyte

	task automatic stray();
		sclk = 1'b0;
		#200 sclk = 1'b1;
		#200;
	endtask : stray

	// Host drives every lane high on release, so the pause pin idles high
	task automatic stop();
		sclk = mode3;
		#200 cs_n = 1'b1;
		lanes = 4'hF;
		#400;
	endtask : stop

	task automatic hold(input logic h);
		sclk = 1'b0;
		#100 lanes[3] = h;
		#100;
	endtask : hold
endmodule : spi_host_model

`default_nettype wire

// ### testbench/flash_front_sva.sv
`timescale 1ns/1ps
`default_nettype none

module flash_front_checker #(
	parameter logic [23:0] ARRAY_LAST = 24'h03FFFF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Serial pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] lane_in,
	input wire logic [3:0] lane_out,
	input wire logic [3:0] lane_oe,
	// Core side
	input wire logic busy,
	input wire logic quad_enable_bit,
	input wire logic rd_req,
	input wire logic [23:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic wr_byte_valid,
	input wire logic [7:0] wr_byte,
	input wire logic cmd_strobe,
	input wire logic [7:0] cmd_opcode,
	input wire logic [23:0] cmd_addr,
	input wire flash_front_pkg::erase_kind_t erase_kind,
	input wire logic [23:0] erase_first,
	input wire logic [23:0] erase_last,
	input wire logic in_standby
);
	import flash_front_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	property p_standby_quiet;
		in_standby |-> lane_oe == 4'h0;
	endproperty
	a_standby_quiet: assert property (p_standby_quiet) else $error("standby drives lanes");
	property p_quad_qe;
		lane_oe == 4'hF |-> quad_enable_bit;
	endproperty
	a_quad_qe: assert property (p_quad_qe) else $error("quad without enable");
	property p_strobe_pulse;
		cmd_strobe |=> !cmd_strobe;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
	property p_strobe_cs;
		cmd_strobe |-> $past(cs_n, 1) && $past(cs_n, 2);
	endproperty
	a_strobe_cs: assert property (p_strobe_cs) else $error("strobe with select low");
	property p_busy_array;
		cmd_strobe && erase_kind != ERASE_NONE |-> !$past(busy);
	endproperty
	a_busy_array: assert property (p_busy_array) else $error("erase while busy");
	property p_sector;
		cmd_strobe && erase_kind == ERASE_SECTOR |-> erase_first[11:0] == 12'h000 && erase_last == (erase_first | 24'h000FFF);
	endproperty
	a_sector: assert property (p_sector) else $error("sector range wrong");
	property p_block64;
		cmd_strobe && erase_kind == ERASE_BLOCK64 |-> erase_first[15:0] == 16'h0000 && erase_last == (erase_first | 24'h00FFFF);
	endproperty
	a_block64: assert property (p_block64) else $error("block range wrong");
	property p_chip;
		cmd_strobe && erase_kind == ERASE_CHIP |-> erase_first == 24'h000000 && erase_last == ARRAY_LAST;
	endproperty
	a_chip: assert property (p_chip) else $error("chip range wrong");
	property p_out_on_fall;
		$changed(lane_out) |-> !$past(sclk, 2);
	endproperty
	a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off fall");
	property p_pause_quiet;
		$fell(lane_in[3]) && lane_oe != 4'hF |-> ##[1:6] lane_oe == 4'h0;
	endproperty
	a_pause_quiet: assert property (p_pause_quiet) else $error("pause left lanes driven");
	property p_cs_release;
		$rose(cs_n) |-> ##[1:6] lane_oe == 4'h0;
	endproperty
	a_cs_release: assert property (p_cs_release) else $error("lanes driven after select");
	c_strobe: cover property (cmd_strobe);
	c_quad: cover property (lane_oe == 4'hF);
	c_standby: cover property (in_standby);
endmodule : flash_front_checker

bind serial_flash_spi_front_end flash_front_checker #(.ARRAY_LAST(ARRAY_LAST)) chk (.*);

`default_nettype wire

// ### testbench/test_serial_flash_spi_front_end.sv
`timescale 1ns/1ps
`default_nettype none

module test_serial_flash_spi_front_end;
	import flash_front_pkg::*;
	localparam logic [23:0] LAST = 24'h03FFFF;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic busy = 1'b0;
	logic quad_enable_bit = 1'b0;
	logic [7:0] rd_data = 8'h00;
	wire logic sclk;
	wire logic cs_n;
	wire logic [3:0] host_lanes;
	logic [3:0] lane_in, lane_out, lane_oe;
	logic rd_req, wr_byte_valid, cmd_strobe, in_standby;
	logic [7:0] wr_byte, cmd_opcode, r, d;
	logic [23:0] rd_addr, cmd_addr, erase_first, erase_last, a;
	erase_kind_t erase_kind;
	int miscompares = 0;
	int checked = 0;
	int strobes = 0;
	int writes = 0;
	int seed = 32'h2738;
	int n, k, s0;
	logic [7:0] ops [4] = '{8'h20, 8'h52, 8'hD8, 8'h60};
	logic [23:0] masks [4] = '{24'h000FFF, 24'h007FFF, 24'h00FFFF, 24'h03FFFF};

	// Each lane is driven by whichever party enables it
	assign lane_in = (lane_oe & lane_out) | (~lane_oe & host_lanes);
	serial_flash_spi_front_end #(.ARRAY_LAST(LAST)) dut (.*);
	spi_host_model host (.sclk(sclk), .cs_n(cs_n), .lanes(host_lanes), .wire_lv(lane_in));

	initial forever #25 mclk = ~mclk;

	// ==========================================================
	// Core model
	function automatic logic [7:0] mem(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h5A;
	endfunction : mem
	always @(posedge mclk) if (rd_req === 1'b1) rd_data <= #2 mem(rd_addr);
	always @(posedge mclk) if (cmd_strobe === 1'b1) strobes++;
	always @(posedge mclk) if (wr_byte_valid === 1'b1) writes++;

	// ==========================================================
	// Tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic head(input logic m, input logic [7:0] op, input int aw, input logic dm);
		host.start(m);
		host.xbyte(op, 1, 1, r);
		if (aw > 0) for (k = 0; k < 3; k++) host.xbyte(a[23 - 8 * k -: 8], aw, aw, r);
		if (dm) host.xbyte(8'h00, aw, aw, r);
	endtask : head
	task automatic core(input logic b, input logic q);
		@(posedge mclk);
		#2 busy = b;
		quad_enable_bit = q;
	endtask : core
	task automatic conclude();
		$display("miscompares %0d checked %0d", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	initial begin
		#2000000;
		miscompares++;
		conclude();
	end

	// ==========================================================
	// Scenarios
	initial begin
		repeat (8) @(posedge mclk);
		#2 reset_n = 1'b1;
		repeat (4) @(posedge mclk);
		#2;
		head(1'b0, 8'hA5, 0, 1'b0);
		host.xbyte(8'h00, 0, 1, r);
		check("standby", 1, in_standby);
		check("oe standby", 0, lane_oe);
		host.stop();
		for (n = 0; n < 2; n++) begin
			a = 24'($random(seed)) & LAST;
			head(n[0], 8'h03, 1, 1'b0);
			host.xbyte(8'h00, 0, 1, r);
			check("read byte", mem(a), r);
			check("oe single", 4'h2, lane_oe);
			check("active", 0, in_standby);
			if (n == 0) begin
				host.hold(1'b0);
				#400 check("oe paused", 0, lane_oe);
				host.hold(1'b1);
			end
			host.xbyte(8'h00, 0, 1, r);
			check("next byte", mem(a + 24'h1), r);
			host.stop();
		end
		a = 24'($random(seed)) & LAST;
		head(1'b0, 8'h3B, 1, 1'b1);
		host.xbyte(8'h00, 0, 2, r);
		check("dual byte", mem(a), r);
		check("oe dual", 4'h3, lane_oe);
		host.stop();
		for (n = 0; n < 2; n++) begin
			core(1'b0, n[0]);
			head(1'b0, 8'h6B, 1, 1'b1);
			host.xbyte(8'h00, 0, 4, r);
			check("oe quad", n ? 4'hF : 4'h0, lane_oe);
			if (n == 1) check("quad byte", mem(a), r);
			host.stop();
		end
		// Status poll before the write-type commands; no address, so the core is asked for 0
		head(1'b0, 8'h05, 0, 1'b0);
		host.xbyte(8'h00, 0, 1, r);
		check("status", mem(24'h000000), r);
		host.stop();
		for (n = 0; n < 4; n++) begin
			a = 24'($random(seed)) & LAST;
			s0 = strobes;
			head(1'b0, ops[n], n < 3 ? 1 : 0, 1'b0);
			host.stop();
			check("strobe", s0 + 1, strobes);
			check("kind", n + 1, erase_kind);
			check("first", a & ~masks[n], erase_first);
			check("last", a | masks[n], erase_last);
		end
		a = 24'($random(seed)) & LAST;
		d = 8'($random(seed));
		s0 = strobes;
		n = writes;
		head(1'b0, 8'h02, 1, 1'b0);
		host.xbyte(d, 1, 1, r);
		host.stop();
		check("strobe program", s0 + 1, strobes);
		check("write pulses", n + 1, writes);
		check("wr byte", d, wr_byte);
		check("cmd addr", a, cmd_addr);
		check("cmd opcode", 8'h02, cmd_opcode);
		check("kind program", 0, erase_kind);
		for (n = 0; n < 2; n++) begin
			s0 = strobes;
			core(n[0], 1'b0);
			head(1'b0, 8'h20, 1, 1'b0);
			if (n == 0) host.stray();
			host.stop();
			check("no strobe", s0, strobes);
		end
		head(1'b0, 8'h03, 1, 1'b0);
		host.xbyte(8'h00, 0, 1, r);
		check("busy read", 1, in_standby);
		host.stop();
		core(1'b0, 1'b0);
		conclude();
	end
endmodule : test_serial_flash_spi_front_end

`default_nettype wire
